// ===== inc/dpt_pkg.sv
package dpt_pkg;
  typedef enum logic [1:0] {CLR_NONE, CLR_GRA, CLR_GRB, CLR_SYNC} dpt_clr_t;
  typedef enum logic [1:0] {OUT_NONE, OUT_LOW, OUT_HIGH, OUT_TOGGLE} dpt_omode_t;
endpackage

// ===== inc/dpt_regs.svh
`ifndef DPT_REGS_SVH
`define DPT_REGS_SVH
// Notes on behaviour
// - Two channels, each with 16-bit up-counter
// - Eight clock choices on each channel
// - Counter cleared by compare or capture event
// - Pin A goes low, high or toggles on match
// - Three interrupt sources per channel, six total
// - One write loads all synchronized counters
// - Clear in one synced channel clears the other if set to CLR_SYNC
// - Synced channels take counter writes in step
// - PWM duty set freely by compare registers
// - PWM plus sync gives two-phase outputs
// - Channel one counts channel two overflows
// - Each register reached in one 16-bit access
// - Standby control stops the prescaler, counting and capture
// - Four pulse pins total, two per channel
// - Edge field: rise, fall, both; divide-by-1 rises
// - Pin B is only a capture input

// Common register byte addresses
`define DPT_START 8'h00
`define DPT_SYNC 8'h04
`define DPT_STBY 8'h08
`define DPT_STAT 8'h0C
`define DPT_MASK 8'h10
`define DPT_CH1 8'h20
`define DPT_CH2 8'h40
// Offsets inside a channel block
`define DPT_O_CTRL 8'h00
`define DPT_O_MODE 8'h04
`define DPT_O_IOC 8'h08
`define DPT_O_CNT 8'h0C
`define DPT_O_GRA 8'h10
`define DPT_O_GRB 8'h14
// Field positions
`define DPT_F_CKS 2:0
`define DPT_F_EDG 4:3
`define DPT_F_CLR 6:5
`define DPT_F_PWM 0
`define DPT_F_OM 1:0
`define DPT_F_CAPA 2
`define DPT_F_CAPB 3
`define DPT_F_CAPF 4
`define DPT_F_CH 1:0
`define DPT_F_STBY 0
`define DPT_F_ST 5:0
// Clock select codes
`define DPT_CK_D1 3'h0
`define DPT_CK_D1024 3'h4
`define DPT_CK_CASC 3'h7
// Edge codes and bus answers
`define DPT_EDG_RISE 2'h0
`define DPT_RESP_OK 2'h0
`define DPT_RESP_ERR 2'h2
`endif

// ===== rtl/dpt_channel.sv
`timescale 1ns/10ps
module dpt_channel #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire dpt_pkg::dpt_clr_t clr_sel,
  input wire dpt_pkg::dpt_omode_t omode,
  input wire logic pwm,
  input wire logic cap_a,
  input wire logic cap_b,
  input wire logic cap_fall,
  // Count and clear
  input wire logic tick,
  input wire logic sync_clr,
  // Register writes
  input wire logic wr_cnt,
  input wire logic wr_gra,
  input wire logic wr_grb,
  input wire logic [CW-1:0] wr_val,
  // Pins
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  output logic pin_a_out,
  output logic pin_a_oe,
  // State and events
  output logic [CW-1:0] count,
  output logic [CW-1:0] gra,
  output logic [CW-1:0] grb,
  output logic ev_a,
  output logic ev_b,
  output logic ev_ovf,
  output logic clr_req
);
  import dpt_pkg::*;

  logic pa_q;
  logic pb_q;
  logic match_a;
  logic match_b;
  logic capt_a;
  logic capt_b;
  logic clr;

  function automatic logic pin_edge(input logic prev, input logic now, input logic fall);
    pin_edge = fall ? (prev && !now) : (!prev && now);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_q <= 1'b0;
      pb_q <= 1'b0;
    end else begin
      pa_q <= pin_a_in;
      pb_q <= pin_b_in;
    end
  end

  // Match fires as the counter leaves the matching value
  assign match_a = tick && !cap_a && (count == gra);
  assign match_b = tick && !cap_b && (count == grb);
  assign capt_a = cap_a && pin_edge(pa_q, pin_a_in, cap_fall);
  assign capt_b = cap_b && pin_edge(pb_q, pin_b_in, cap_fall);
  assign ev_a = match_a || capt_a;
  assign ev_b = match_b || capt_b;
  assign ev_ovf = tick && (count == '1);
  assign clr_req = ((clr_sel == CLR_GRA) && ev_a) || ((clr_sel == CLR_GRB) && ev_b);
  assign clr = clr_req || ((clr_sel == CLR_SYNC) && sync_clr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (wr_cnt) begin
      count <= wr_val;
    end else if (clr) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gra <= '1;
      grb <= '1;
    end else begin
      if (wr_gra) begin
        gra <= wr_val;
      end else if (capt_a) begin
        gra <= count;
      end
      if (wr_grb) begin
        grb <= wr_val;
      end else if (capt_b) begin
        grb <= count;
      end
    end
  end

  // Pin A is the only output; pin B never drives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_a_out <= 1'b0;
    end else if (pwm) begin
      if (match_b) begin
        pin_a_out <= 1'b0;
      end else if (match_a) begin
        pin_a_out <= 1'b1;
      end
    end else if (match_a) begin
      case (omode)
        OUT_LOW: pin_a_out <= 1'b0;
        OUT_HIGH: pin_a_out <= 1'b1;
        OUT_TOGGLE: pin_a_out <= !pin_a_out;
        default: pin_a_out <= pin_a_out;
      endcase
    end
  end

  assign pin_a_oe = !cap_a && (pwm || (omode != OUT_NONE));

  default clocking dck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_count_step: assert property (
    tick && !clr && !wr_cnt |=> count == $past(count) + 1'b1)
    else $error("counter did not step on tick");
  chk_wrap_ovf: assert property (
    ev_ovf && !clr && !wr_cnt |=> count == '0)
    else $error("overflow did not wrap to zero");
  chk_clear_zero: assert property (
    clr_req && !wr_cnt |=> count == '0)
    else $error("clear source did not clear counter");
  chk_capture_a: assert property (
    capt_a && !wr_gra |=> gra == $past(count))
    else $error("capture did not latch counter");
  chk_toggle_a: assert property (
    match_a && !pwm && omode == OUT_TOGGLE |=> pin_a_out != $past(pin_a_out))
    else $error("pin A did not toggle on match");
  chk_pwm_low: assert property (
    pwm && match_b ##1 !match_a [*2] |=> !pin_a_out)
    else $error("pwm output not low after B match");
endmodule

// ===== rtl/dpt_prescale.sv
`timescale 1ns/10ps
module dpt_prescale #(
  parameter int DIVW = 10
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Run enable
  input wire logic run,
  // Edges of phi/4, /16, /64, /256, /1024
  output logic [4:0] rise,
  output logic [4:0] fall
);
  logic [DIVW-1:0] pre;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre <= '0;
    end else if (run) begin
      pre <= pre + 1'b1;
    end
  end

  // Divided clock rises at count zero, falls half way
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      rise[k] = run && ((pre & DIVW'((1 << (2 * k + 2)) - 1)) == '0);
      fall[k] = run && ((pre & DIVW'((1 << (2 * k + 2)) - 1)) == DIVW'(1 << (2 * k + 1)));
    end
  end
endmodule

// ===== rtl/dpt_top.sv
`timescale 1ns/10ps
`include "dpt_regs.svh"
module dpt_top #(
  parameter int AW = 8,
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // External count clocks
  input wire logic ext_clock_a,
  input wire logic ext_clock_b,
  input wire logic ext_clock_c,
  // Channel 1 pins
  input wire logic ch1_pin_a_in,
  output logic ch1_pin_a_out,
  output logic ch1_pin_a_oe,
  input wire logic ch1_pin_b,
  // Channel 2 pins
  input wire logic ch2_pin_a_in,
  output logic ch2_pin_a_out,
  output logic ch2_pin_a_oe,
  input wire logic ch2_pin_b,
  // Interrupt
  output logic irq
);
  import dpt_pkg::*;

  // Configuration
  logic [1:0] start;
  logic [1:0] sync;
  logic stby;
  logic [5:0] mask;
  logic [5:0] stat;
  logic [2:0] cks [2];
  logic [1:0] edg [2];
  dpt_clr_t clr [2];
  logic pwm [2];
  dpt_omode_t omode [2];
  logic cap_a [2];
  logic cap_b [2];
  logic cap_f [2];

  // Channel state
  logic [CW-1:0] cnt [2];
  logic [CW-1:0] gra [2];
  logic [CW-1:0] grb [2];
  logic [1:0] ev_a;
  logic [1:0] ev_b;
  logic [1:0] ev_ovf;
  logic [1:0] clr_req;
  logic [1:0] tick;
  logic [1:0] sclr;
  logic [1:0] wload;
  logic [1:0] wgra;
  logic [1:0] wgrb;
  logic [1:0] pin_a_in;
  logic [1:0] pin_b_in;
  logic [1:0] pin_a_out;
  logic [1:0] pin_a_oe;
  logic [5:0] ev;

  // Clock sources
  logic [4:0] rise;
  logic [4:0] fall;
  logic [2:0] xq;
  logic [2:0] xr;
  logic [2:0] xf;
  logic [7:0] rv [2];
  logic [7:0] fv [2];

  // Bus
  logic aw_got;
  logic w_got;
  logic wr_go;
  logic rd_go;
  logic [AW-1:0] aw_q;
  logic [15:0] w_q;
  logic [1:0] s_q;
  logic [16:0] wr_cur;
  logic [16:0] rd_cur;
  logic [15:0] wv;

  function automatic logic [AW-1:0] chb(input int c);
    chb = (c == 0) ? AW'(`DPT_CH1) : AW'(`DPT_CH2);
  endfunction

  // Bit 16 flags a mapped address, low half is the value
  function automatic logic [16:0] reg_val(input logic [AW-1:0] a);
    logic [16:0] r;
    r = '0;
    case (a)
      AW'(`DPT_START): begin
        r[16] = 1'b1;
        r[`DPT_F_CH] = start;
      end
      AW'(`DPT_SYNC): begin
        r[16] = 1'b1;
        r[`DPT_F_CH] = sync;
      end
      AW'(`DPT_STBY): begin
        r[16] = 1'b1;
        r[`DPT_F_STBY] = stby;
      end
      AW'(`DPT_STAT): begin
        r[16] = 1'b1;
        r[`DPT_F_ST] = stat;
      end
      AW'(`DPT_MASK): begin
        r[16] = 1'b1;
        r[`DPT_F_ST] = mask;
      end
      default: r = '0;
    endcase
    for (int c = 0; c < 2; c++) begin
      if (a == chb(c) + AW'(`DPT_O_CTRL)) begin
        r[16] = 1'b1;
        r[`DPT_F_CKS] = cks[c];
        r[`DPT_F_EDG] = edg[c];
        r[`DPT_F_CLR] = clr[c];
      end
      if (a == chb(c) + AW'(`DPT_O_MODE)) begin
        r[16] = 1'b1;
        r[`DPT_F_PWM] = pwm[c];
      end
      if (a == chb(c) + AW'(`DPT_O_IOC)) begin
        r[16] = 1'b1;
        r[`DPT_F_OM] = omode[c];
        r[`DPT_F_CAPA] = cap_a[c];
        r[`DPT_F_CAPB] = cap_b[c];
        r[`DPT_F_CAPF] = cap_f[c];
      end
      if (a == chb(c) + AW'(`DPT_O_CNT)) begin
        r = {1'b1, cnt[c]};
      end
      if (a == chb(c) + AW'(`DPT_O_GRA)) begin
        r = {1'b1, gra[c]};
      end
      if (a == chb(c) + AW'(`DPT_O_GRB)) begin
        r = {1'b1, grb[c]};
      end
    end
    reg_val = r;
  endfunction

  // Edge selection; divide-by-1 always counts every cycle
  function automatic logic pick(input logic [2:0] s, input logic [1:0] e,
                                input logic [7:0] r, input logic [7:0] f);
    if (s == `DPT_CK_D1) begin
      pick = r[0];
    end else if (e[1]) begin
      pick = r[s] || f[s];
    end else begin
      pick = e[0] ? f[s] : r[s];
    end
  endfunction

  dpt_prescale dpt_prescale_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(!stby),
    .rise(rise),
    .fall(fall)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xq <= '0;
    end else begin
      xq <= {ext_clock_c, ext_clock_b, ext_clock_a};
    end
  end

  assign xr = {ext_clock_c, ext_clock_b, ext_clock_a} & ~xq;
  assign xf = ~{ext_clock_c, ext_clock_b, ext_clock_a} & xq;

  // Source tables; channel 1 code 7 is channel 2 overflow
  always_comb begin
    rv[0] = {ev_ovf[1], xr[1:0], rise[3:0], 1'b1};
    fv[0] = {ev_ovf[1], xf[1:0], fall[3:0], 1'b1};
    rv[1] = {xr, rise[4], rise[2:0], 1'b1};
    fv[1] = {xf, fall[4], fall[2:0], 1'b1};
    for (int c = 0; c < 2; c++) begin
      tick[c] = start[c] && !stby && pick(cks[c], edg[c], rv[c], fv[c]);
    end
  end

  assign pin_a_in = {ch2_pin_a_in, ch1_pin_a_in};
  assign pin_b_in = {ch2_pin_b, ch1_pin_b};
  assign ch1_pin_a_out = pin_a_out[0];
  assign ch1_pin_a_oe = pin_a_oe[0];
  assign ch2_pin_a_out = pin_a_out[1];
  assign ch2_pin_a_oe = pin_a_oe[1];

  // Synced channels share counter loads and clears
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      wload[c] = wr_go && ((aw_q == chb(c) + AW'(`DPT_O_CNT))
                 || ((&sync) && (aw_q == chb(1 - c) + AW'(`DPT_O_CNT))));
      wgra[c] = wr_go && (aw_q == chb(c) + AW'(`DPT_O_GRA));
      wgrb[c] = wr_go && (aw_q == chb(c) + AW'(`DPT_O_GRB));
      sclr[c] = (&sync) && clr_req[1 - c];
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_ch
    dpt_channel #(.CW(CW)) dpt_channel_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr_sel(clr[c]),
      .omode(omode[c]),
      .pwm(pwm[c]),
      .cap_a(cap_a[c] && !stby),
      .cap_b(cap_b[c] && !stby),
      .cap_fall(cap_f[c]),
      .tick(tick[c]),
      .sync_clr(sclr[c]),
      .wr_cnt(wload[c]),
      .wr_gra(wgra[c]),
      .wr_grb(wgrb[c]),
      .wr_val(CW'(wv)),
      .pin_a_in(pin_a_in[c]),
      .pin_b_in(pin_b_in[c]),
      .pin_a_out(pin_a_out[c]),
      .pin_a_oe(pin_a_oe[c]),
      .count(cnt[c]),
      .gra(gra[c]),
      .grb(grb[c]),
      .ev_a(ev_a[c]),
      .ev_b(ev_b[c]),
      .ev_ovf(ev_ovf[c]),
      .clr_req(clr_req[c])
    );
  end

  // Write channel: address and data taken in either order
  assign awready = !aw_got && !bvalid;
  assign wready = !w_got && !bvalid;
  assign wr_go = aw_got && w_got && !bvalid;
  always_comb wr_cur = reg_val(aw_q);
  assign wv = {s_q[1] ? w_q[15:8] : wr_cur[15:8], s_q[0] ? w_q[7:0] : wr_cur[7:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      s_q <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_q <= wdata[15:0];
        s_q <= wstrb[1:0];
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `DPT_RESP_OK;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_cur[16] ? `DPT_RESP_OK : `DPT_RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel
  assign arready = !rvalid;
  assign rd_go = arvalid && arready;
  always_comb rd_cur = reg_val(araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `DPT_RESP_OK;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata <= 32'(rd_cur[15:0]);
      rresp <= rd_cur[16] ? `DPT_RESP_OK : `DPT_RESP_ERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start <= '0;
      sync <= '0;
      stby <= 1'b0;
      mask <= '0;
      for (int c = 0; c < 2; c++) begin
        cks[c] <= '0;
        edg[c] <= '0;
        clr[c] <= CLR_NONE;
        pwm[c] <= 1'b0;
        omode[c] <= OUT_NONE;
        cap_a[c] <= 1'b0;
        cap_b[c] <= 1'b0;
        cap_f[c] <= 1'b0;
      end
    end else if (wr_go) begin
      if (aw_q == AW'(`DPT_START)) begin
        start <= wv[`DPT_F_CH];
      end
      if (aw_q == AW'(`DPT_SYNC)) begin
        sync <= wv[`DPT_F_CH];
      end
      if (aw_q == AW'(`DPT_STBY)) begin
        stby <= wv[`DPT_F_STBY];
      end
      if (aw_q == AW'(`DPT_MASK)) begin
        mask <= wv[`DPT_F_ST];
      end
      for (int c = 0; c < 2; c++) begin
        if (aw_q == chb(c) + AW'(`DPT_O_CTRL)) begin
          cks[c] <= wv[`DPT_F_CKS];
          edg[c] <= wv[`DPT_F_EDG];
          clr[c] <= dpt_clr_t'(wv[`DPT_F_CLR]);
        end
        if (aw_q == chb(c) + AW'(`DPT_O_MODE)) begin
          pwm[c] <= wv[`DPT_F_PWM];
        end
        if (aw_q == chb(c) + AW'(`DPT_O_IOC)) begin
          omode[c] <= dpt_omode_t'(wv[`DPT_F_OM]);
          cap_a[c] <= wv[`DPT_F_CAPA];
          cap_b[c] <= wv[`DPT_F_CAPB];
          cap_f[c] <= wv[`DPT_F_CAPF];
        end
      end
    end
  end

  // Sticky status; a new event beats the read clear
  assign ev = {ev_ovf[1], ev_b[1], ev_a[1], ev_ovf[0], ev_b[0], ev_a[0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= '0;
    end else if (rd_go && (araddr == AW'(`DPT_STAT))) begin
      stat <= ev;
    end else begin
      stat <= stat | ev;
    end
  end

  assign irq = |(stat & mask);

  default clocking dck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_sync_load: assert property (
    wload[0] && (&sync) |=> cnt[0] == cnt[1])
    else $error("synced counters differ after load");
  chk_sync_clear: assert property (
    clr_req[0] && (&sync) && clr[1] == CLR_SYNC && !wload[1] |=> cnt[1] == '0)
    else $error("synced channel not cleared");
  chk_standby_stop: assert property (
    stby |-> tick == '0 ##1 $stable(cnt[0]) || $past(wload[0]) || $past(clr_req[0]))
    else $error("counting during standby");
  chk_div1_edge: assert property (
    start[0] && !stby && cks[0] == `DPT_CK_D1 |-> tick[0])
    else $error("divide-by-1 did not count every cycle");
  chk_cascade: assert property (
    start[0] && !stby && cks[0] == `DPT_CK_CASC |-> tick[0] == ev_ovf[1])
    else $error("cascade tick does not follow overflow");
  chk_ch2_slow: assert property (
    start[1] && !stby && cks[1] == `DPT_CK_D1024 && edg[1] == `DPT_EDG_RISE |-> tick[1] == rise[4])
    else $error("slowest clock mismatch on channel 2");
  chk_event_sticky: assert property (
    ev[2] |=> stat[2] ##1 (stat[2] || $past(rd_go && araddr == AW'(`DPT_STAT))))
    else $error("overflow event not held in status");
  chk_read_clear: assert property (
    rd_go && araddr == AW'(`DPT_STAT) && ev == '0 |=> stat == '0 && rvalid && rdata[5:0] == $past(stat))
    else $error("status read did not clear");

  cov_ovf: cover property (ev_ovf[1]);
  cov_sync_clr: cover property (sclr[1] && clr[1] == CLR_SYNC);
  cov_two_phase: cover property (pwm[0] && pwm[1] && (&sync) && (&start));
  cov_irq: cover property (!irq ##1 irq);
endmodule

// ===== test/dpt_pins_model.sv
`timescale 1ns/10ps
module dpt_pins_model (
  // Clock
  input wire logic aclk,
  // Pin levels: ext a, ext b, ext c, ch1 pin b, ch1 pin a
  output logic [4:0] lvl
);
  initial lvl = 5'h00;
  // Two cycles high, two low, so the edge detector sees every change
  task automatic pulse(input int line, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge aclk);
      lvl[line] <= 1'b1;
      repeat (2) @(posedge aclk);
      lvl[line] <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask
endmodule

// ===== test/dual_channel_pulse_timer_test.sv
`timescale 1ns/10ps
`include "dpt_regs.svh"
module dual_channel_pulse_timer_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq, p1o, p1e, p2o, p2e;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata;
  logic [15:0] rd, v1;
  logic [4:0] lvl;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int hi;
  int hi2;
  logic [15:0] om [4] = '{16'h0002, 16'h0003, 16'h0002, 16'h0001};
  logic pv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [15:0] ec [4] = '{16'h0005, 16'h000E, 16'h0017, 16'h0011};
  logic [15:0] ex [4] = '{16'h0003, 16'h0003, 16'h0006, 16'h000A};

  dpt_top dpt_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_clock_a(lvl[0]), .ext_clock_b(lvl[1]), .ext_clock_c(lvl[2]),
    .ch1_pin_a_in(lvl[4]), .ch1_pin_a_out(p1o), .ch1_pin_a_oe(p1e), .ch1_pin_b(lvl[3]),
    .ch2_pin_a_in(1'b0), .ch2_pin_a_out(p2o), .ch2_pin_a_oe(p2e), .ch2_pin_b(1'b0),
    .irq(irq)
  );
  dpt_pins_model pins_i (.aclk(aclk), .lvl(lvl));

  always #4 aclk = ~aclk;

  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // Flags are sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdt(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      rd = rdata[15:0];
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    rdt(a);
    chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, rd});
  endtask

  // Pin read mid-cycle; the next call starts after a rising edge
  task automatic pin(input string nm, input logic e, input int s);
    logic g;
    @(negedge aclk);
    case (s)
      0: g = irq;
      1: g = p2o;
      2: g = p2e;
      default: g = p1e;
    endcase
    chk(nm, 32'(e), 32'(g));
    @(posedge aclk);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`DPT_CH1 + `DPT_O_GRA, 16'hFFFF);
    rc(`DPT_CH2 + `DPT_O_CNT, 16'h0000);
    rdt(8'hFC);
    chk("rresp", 32'(`DPT_RESP_ERR), 32'(rs));
    wr(8'hFC, 16'h0001);
    chk("bresp", 32'(`DPT_RESP_ERR), 32'(rs));
    wstrb <= 4'h1;
    wr(`DPT_CH1 + `DPT_O_GRA, 16'h0000);
    wstrb <= 4'hF;
    rc(`DPT_CH1 + `DPT_O_GRA, 16'hFF00);
    // Synchronised load and clear
    wr(`DPT_SYNC, 16'h0003);
    wr(`DPT_CH1 + `DPT_O_CNT, 16'h1234);
    rc(`DPT_CH2 + `DPT_O_CNT, 16'h1234);
    wr(`DPT_CH1 + `DPT_O_CTRL, 16'h0020);
    wr(`DPT_CH1 + `DPT_O_GRA, 16'h0009);
    wr(`DPT_CH2 + `DPT_O_CTRL, 16'h0060);
    wr(`DPT_CH1 + `DPT_O_CNT, 16'h0000);
    wr(`DPT_START, 16'h0003);
    repeat (40) @(posedge aclk);
    wr(`DPT_START, 16'h0000);
    rdt(`DPT_CH1 + `DPT_O_CNT);
    v1 = rd;
    rdt(`DPT_CH2 + `DPT_O_CNT);
    chk("sync count", {16'h0000, v1}, {16'h0000, rd});
    chk("clear bound", 32'h0000_0001, 32'(v1 <= 16'h0009));
    wr(`DPT_SYNC, 16'h0000);
    wr(`DPT_CH1 + `DPT_O_CTRL, 16'h0000);
    wr(`DPT_CH2 + `DPT_O_CTRL, 16'h0000);
    // Overflow, mask and read-clear
    rdt(`DPT_STAT);
    wr(`DPT_MASK, 16'h0004);
    wr(`DPT_CH1 + `DPT_O_CNT, 16'hFFF0);
    wr(`DPT_START, 16'h0001);
    repeat (40) @(posedge aclk);
    wr(`DPT_START, 16'h0000);
    pin("irq", 1'b1, 0);
    rc(`DPT_STAT, 16'h0007);
    pin("irq", 1'b0, 0);
    // Compare output modes on channel 2
    wr(`DPT_CH2 + `DPT_O_GRA, 16'h0005);
    for (int i = 0; i < 4; i++) begin
      wr(`DPT_START, 16'h0000);
      wr(`DPT_CH2 + `DPT_O_IOC, om[i]);
      wr(`DPT_CH2 + `DPT_O_CNT, 16'h0000);
      wr(`DPT_START, 16'h0002);
      repeat (20) @(posedge aclk);
      pin("ch2 pin a", pv[i], 1);
      pin("ch2 pin a oe", 1'b1, 2);
    end
    wr(`DPT_START, 16'h0000);
    // PWM: period 8, ch1 high 5 of 8, synced ch2 high 2 of 8
    wr(`DPT_SYNC, 16'h0003);
    wr(`DPT_CH1 + `DPT_O_CTRL, 16'h0040);
    wr(`DPT_CH1 + `DPT_O_GRA, 16'h0002);
    wr(`DPT_CH1 + `DPT_O_GRB, 16'h0007);
    wr(`DPT_CH1 + `DPT_O_MODE, 16'h0001);
    wr(`DPT_CH2 + `DPT_O_CTRL, 16'h0060);
    wr(`DPT_CH2 + `DPT_O_GRA, 16'h0004);
    wr(`DPT_CH2 + `DPT_O_GRB, 16'h0006);
    wr(`DPT_CH2 + `DPT_O_MODE, 16'h0001);
    wr(`DPT_CH1 + `DPT_O_CNT, 16'h0000);
    wr(`DPT_START, 16'h0003);
    repeat (16) @(posedge aclk);
    hi = 0;
    hi2 = 0;
    repeat (64) begin
      @(negedge aclk);
      if (p1o === 1'b1) hi++;
      if (p2o === 1'b1) hi2++;
    end
    @(posedge aclk);
    chk("pwm high cycles", 32'd40, 32'(hi));
    chk("second phase high cycles", 32'd16, 32'(hi2));
    wr(`DPT_START, 16'h0000);
    wr(`DPT_SYNC, 16'h0000);
    wr(`DPT_CH1 + `DPT_O_MODE, 16'h0000);
    wr(`DPT_CH2 + `DPT_O_MODE, 16'h0000);
    // Cascade: channel 1 counts channel 2 overflows
    wr(`DPT_CH1 + `DPT_O_CTRL, 16'h0007);
    wr(`DPT_CH1 + `DPT_O_CNT, 16'h0000);
    wr(`DPT_CH2 + `DPT_O_CTRL, 16'h0005);
    wr(`DPT_CH2 + `DPT_O_CNT, 16'hFFFE);
    wr(`DPT_START, 16'h0003);
    pins_i.pulse(0, 3);
    wr(`DPT_START, 16'h0000);
    rc(`DPT_CH2 + `DPT_O_CNT, 16'h0001);
    rc(`DPT_CH1 + `DPT_O_CNT, 16'h0001);
    // External sources, a /4 prescaler tap, and edge choices
    for (int i = 0; i < 4; i++) begin
      wr(`DPT_CH2 + `DPT_O_CTRL, ec[i]);
      wr(`DPT_CH2 + `DPT_O_CNT, 16'h0000);
      wr(`DPT_START, 16'h0002);
      pins_i.pulse(i, 3);
      wr(`DPT_START, 16'h0000);
      rc(`DPT_CH2 + `DPT_O_CNT, ex[i]);
    end
    // Standby freezes counting
    wr(`DPT_STBY, 16'h0001);
    wr(`DPT_CH2 + `DPT_O_CTRL, 16'h0005);
    wr(`DPT_CH2 + `DPT_O_CNT, 16'h0000);
    wr(`DPT_START, 16'h0002);
    pins_i.pulse(0, 3);
    wr(`DPT_START, 16'h0000);
    wr(`DPT_STBY, 16'h0000);
    rc(`DPT_CH2 + `DPT_O_CNT, 16'h0000);
    // Capture on both pins, counter held by idle cascade source
    rdt(`DPT_STAT);
    wr(`DPT_CH1 + `DPT_O_CNT, 16'h1234);
    wr(`DPT_CH1 + `DPT_O_IOC, 16'h000C);
    wr(`DPT_START, 16'h0001);
    pins_i.pulse(3, 1);
    pins_i.pulse(4, 1);
    wr(`DPT_START, 16'h0000);
    pin("ch1 pin a oe", 1'b0, 3);
    rc(`DPT_CH1 + `DPT_O_GRB, 16'h1234);
    rc(`DPT_CH1 + `DPT_O_GRA, 16'h1234);
    rc(`DPT_STAT, 16'h0003);
    end_sim();
  end
endmodule
